// ---- core/ramp_timer.v ----
`timescale 1ns/1ps
`default_nettype none

`include "sequencer_defs.vh"

// Shared timing ramp: counts one ramp period while running, held at zero
// otherwise. Used for soft-start, settling and the fault timer alike.
module ramp_timer #(
    parameter [`RAMP_W-1:0] PERIOD = `RAMP_CYCLES
) (
    // Clock and reset
    input  wire               sys_clk,
    input  wire               rst,
    // Control
    input  wire               run,
    // Ramp state
    output wire [`RAMP_W-1:0] level,
    output wire               period_end
);

    reg [`RAMP_W-1:0] count_q;

    assign period_end = run && (count_q == PERIOD - 1'b1);
    assign level      = count_q;

    always @(posedge sys_clk) begin
        if (rst || !run || period_end) begin
            count_q <= {`RAMP_W{1'b0}};
        end else begin
            count_q <= count_q + 1'b1;
        end
    end

endmodule // ramp_timer

`default_nettype wire

// ---- core/sequencer_defs.vh ----
`ifndef SEQUENCER_DEFS_VH
`define SEQUENCER_DEFS_VH

// ****************************************
// Timing figures and derived cycle counts
// ****************************************
// System clock rate in kHz (40 MHz)
`define CLK_KHZ            40000
// Timing ramp period in ms, as set by a 10nF timing capacitor
`define RAMP_PERIOD_MS     6
// Cycles in one ramp period: 6 ms at 40 MHz, sized to the ramp counter
`define RAMP_CYCLES        24'h03A980
// Ready flag release delay in us
`define READY_DELAY_US     15
// Cycles in the ready flag delay: 15 us at 40 MHz is 600 cycles
`define READY_DELAY_CYCLES 12'h258

// ****************************************
// Ramp periods spent in startup
// ****************************************
// Three stages of one period each
`define STARTUP_PERIODS    3

// ****************************************
// Sequencer state codes
// ****************************************
`define ST_OFF             3'h0
`define ST_BOOST           3'h1
`define ST_NEG             3'h2
`define ST_POS             3'h3
`define ST_RUN             3'h4
`define ST_FAULT           3'h5
`define ST_LATCHED         3'h6

// ****************************************
// Counter widths and reset values
// ****************************************
`define RAMP_W             24
`define DELAY_W            12
`define STATE_RESET        3'h0
`define READY_N_RESET      1'h1

`endif

// ---- core/sync_2ff.v ----
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for one asynchronous level
module sync_2ff (
    // Clock and reset
    input  wire sys_clk,
    input  wire rst,
    // Level
    input  wire din,
    output wire dout
);

    reg meta_q;
    reg sync_q;

    always @(posedge sys_clk) begin
        if (rst) begin
            meta_q <= 1'h0;
            sync_q <= 1'h0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;

endmodule // sync_2ff

`default_nettype wire

// ---- core/tri_rail_sequencer_fault_timer.v ----
// Contract
// - Ready flag stays high in startup, goes low once done with all rails good
// - After startup, a rail under 80% raises ready after about 15 us
// - Each rail has its own comparator; any low starts timer, raises ready
// - Fault timer reuses the soft-start timing ramp, no separate timebase
// - Fault still present at end of one ramp period disables all outputs
// - After fault shutdown stay off until on/off cycles or power returns
// - Fault clearing before timer expiry drops ready low, no retained state
// - On/off high turns on; low disables every output at once
// - Start on on/off rising, or on/off high while supply leaves lockout
// - Outputs turn on boost first, then negative rail, then positive rail
// - Each output soft-starts over one timing ramp period
// - Each stage gets one ramp period to settle; negative rail tracks ramp
// - At startup end with all rails good, ramp held at ground, ready low
// - Rail still low at startup end keeps ready high, starts fault ramp
// - Supply lockout hysteresis is analog; block sees a clean good level

`timescale 1ns/1ps
`default_nettype none

`include "sequencer_defs.vh"

module tri_rail_sequencer_fault_timer #(
    parameter [`RAMP_W-1:0]  RAMP_CYCLES  = `RAMP_CYCLES,
    parameter [`DELAY_W-1:0] READY_CYCLES = `READY_DELAY_CYCLES
) (
    // Clock and reset
    input  wire               sys_clk,
    input  wire               rst,
    // Control pins
    input  wire               enable_pin,
    input  wire               supply_lockout_good,
    // Under-80% comparators, high while the rail is low
    input  wire               boost_feedback_low,
    input  wire               negative_rail_feedback_low,
    input  wire               positive_rail_feedback_low,
    // Rail enables
    output reg                boost_enable,
    output reg                negative_rail_enable,
    output reg                positive_rail_enable,
    // Soft-start strobes, high while the rail ramps
    output reg                boost_soft_start,
    output reg                negative_rail_soft_start,
    output reg                positive_rail_soft_start,
    // Status
    output reg                ready_n,
    output wire [`RAMP_W-1:0] timing_ramp
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    wire en_s;
    wire uv_ok_s;
    wire fb1_low_s;
    wire fb2_low_s;
    wire fb3_low_s;

    sync_2ff u_sync_en (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     (enable_pin),
        .dout    (en_s)
    );

    sync_2ff u_sync_uv (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     (supply_lockout_good),
        .dout    (uv_ok_s)
    );

    sync_2ff u_sync_fb1 (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     (boost_feedback_low),
        .dout    (fb1_low_s)
    );

    sync_2ff u_sync_fb2 (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     (negative_rail_feedback_low),
        .dout    (fb2_low_s)
    );

    sync_2ff u_sync_fb3 (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     (positive_rail_feedback_low),
        .dout    (fb3_low_s)
    );

    // ****************************************
    // State and ramp
    // ****************************************
    reg  [2:0]          state_q;
    reg  [2:0]          state_d;
    reg                 on_q;
    reg  [`DELAY_W-1:0] delay_q;
    reg  [`DELAY_W-1:0] delay_d;
    wire                ramp_run;
    wire                ramp_end;
    wire                any_low;
    wire                on_now;
    wire                start_req;

    assign any_low = fb1_low_s | fb2_low_s | fb3_low_s;

    // Lockout hysteresis handled in the analog front end
    assign on_now = en_s & uv_ok_s;

    // Start on enable rise or lockout release
    assign start_req = on_now & ~on_q;

    // Ramp only runs in stages and fault timing, else at ground
    assign ramp_run = (state_q == `ST_BOOST) || (state_q == `ST_NEG) ||
                      (state_q == `ST_POS)   || (state_q == `ST_FAULT);

    // One ramp serves soft-start and fault timer
    ramp_timer #(
        .PERIOD (RAMP_CYCLES)
    ) u_ramp (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .run        (ramp_run),
        .level      (timing_ramp),
        .period_end (ramp_end)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    always @* begin
        state_d = state_q;
        // Off at once when on/off low or supply lost
        // Only a fresh on transition leaves shutdown
        if (!on_now) begin
            state_d = `ST_OFF;
        end else begin
            case (state_q)
                `ST_OFF: begin
                    if (start_req) begin
                        state_d = `ST_BOOST;
                    end
                end
                `ST_BOOST: begin
                    if (ramp_end) begin
                        state_d = `ST_NEG;
                    end
                end
                `ST_NEG: begin
                    if (ramp_end) begin
                        state_d = `ST_POS;
                    end
                end
                `ST_POS: begin
                    if (ramp_end) begin
                        // Low rail at end goes to fault timing
                        state_d = any_low ? `ST_FAULT : `ST_RUN;
                    end
                end
                `ST_RUN: begin
                    if (any_low) begin
                        state_d = `ST_FAULT;
                    end
                end
                `ST_FAULT: begin
                    if (!any_low) begin
                        state_d = `ST_RUN;
                    // Fault outlasts the period, shut down
                    end else if (ramp_end) begin
                        state_d = `ST_LATCHED;
                    end
                end
                `ST_LATCHED: begin
                    state_d = `ST_LATCHED;
                end
                default: begin
                    state_d = `ST_OFF;
                end
            endcase
        end
    end

    // Ready filter counter: counts while running with a fault
    always @* begin
        delay_d = {`DELAY_W{1'b0}};
        // Fault must persist for the whole filter count
        if ((state_q == `ST_FAULT) && any_low && (delay_q != READY_CYCLES)) begin
            delay_d = delay_q + 1'b1;
        end else if ((state_q == `ST_FAULT) && any_low) begin
            delay_d = delay_q;
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            state_q <= `STATE_RESET;
            on_q    <= 1'h0;
            delay_q <= {`DELAY_W{1'b0}};
        end else begin
            state_q <= state_d;
            on_q    <= on_now;
            delay_q <= delay_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Startup-end fault entry never had ready low, so it stays high there
    reg was_running_q;

    always @(posedge sys_clk) begin
        if (rst) begin
            was_running_q <= 1'h0;
        end else if (state_q == `ST_RUN) begin
            was_running_q <= 1'h1;
        end else if (state_q != `ST_FAULT) begin
            was_running_q <= 1'h0;
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            boost_enable             <= 1'h0;
            negative_rail_enable     <= 1'h0;
            positive_rail_enable     <= 1'h0;
            boost_soft_start         <= 1'h0;
            negative_rail_soft_start <= 1'h0;
            positive_rail_soft_start <= 1'h0;
            ready_n                  <= `READY_N_RESET;
        end else begin
            // Each enable stays on from its own stage onward
            boost_enable         <= (state_d != `ST_OFF) &&
                                    (state_d != `ST_LATCHED);
            negative_rail_enable <= (state_d == `ST_NEG) ||
                                    (state_d == `ST_POS) ||
                                    (state_d == `ST_RUN) ||
                                    (state_d == `ST_FAULT);
            positive_rail_enable <= (state_d == `ST_POS) ||
                                    (state_d == `ST_RUN) ||
                                    (state_d == `ST_FAULT);
            // Soft-start strobe spans its ramp period
            boost_soft_start         <= (state_d == `ST_BOOST);
            negative_rail_soft_start <= (state_d == `ST_NEG);
            positive_rail_soft_start <= (state_d == `ST_POS);
            if (state_d == `ST_RUN) begin
                ready_n <= 1'h0;
            end else if ((state_d == `ST_FAULT) && was_running_q &&
                         (delay_q != READY_CYCLES)) begin
                ready_n <= 1'h0;
            end else begin
                ready_n <= 1'h1;
            end
        end
    end

endmodule // tri_rail_sequencer_fault_timer

`default_nettype wire

// ---- testbench/rail_plant_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************
// Regulators and comparators
// ****************************
module rail_plant_model (
    // Rail enables
    input wire logic       boost_enable,
    input wire logic       negative_rail_enable,
    input wire logic       positive_rail_enable,
    // Droop forced by the bench, one bit a rail
    input wire logic [2:0] droop,
    // High while a rail is under 80%
    output logic           boost_feedback_low,
    output logic           negative_rail_feedback_low,
    output logic           positive_rail_feedback_low
);
    // one comparator each
    // A rail that is off reads low, so startup must not trust it
    assign boost_feedback_low = !boost_enable || droop[0];
    assign negative_rail_feedback_low = !negative_rail_enable || droop[1];
    assign positive_rail_feedback_low = !positive_rail_enable || droop[2];
endmodule // rail_plant_model
`default_nettype wire

// ---- testbench/tri_rail_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sequencer_defs.vh"
// ****************************
// Sequencer port checker
// ****************************
module tri_rail_monitor #(
    parameter [`RAMP_W-1:0]  RAMP_CYCLES  = `RAMP_CYCLES,
    parameter [`DELAY_W-1:0] READY_CYCLES = `READY_DELAY_CYCLES
) (
    // Clock and reset
    input wire logic               sys_clk,
    input wire logic               rst,
    // Pins and comparators
    input wire logic               enable_pin,
    input wire logic               supply_lockout_good,
    input wire logic               boost_feedback_low,
    input wire logic               negative_rail_feedback_low,
    input wire logic               positive_rail_feedback_low,
    // Rail controls and status
    input wire logic               boost_enable,
    input wire logic               negative_rail_enable,
    input wire logic               positive_rail_enable,
    input wire logic               boost_soft_start,
    input wire logic               negative_rail_soft_start,
    input wire logic               positive_rail_soft_start,
    input wire logic               ready_n,
    input wire logic [`RAMP_W-1:0] timing_ramp
);
    wire all_on = boost_enable & negative_rail_enable & positive_rail_enable;
    wire any_ss = boost_soft_start | negative_rail_soft_start |
                  positive_rail_soft_start;
    wire any_low = boost_feedback_low | negative_rail_feedback_low |
                   positive_rail_feedback_low;
    // Pins pass two sync flops, so the limits below carry a small margin
    logic [`RAMP_W-1:0] flt_q;
    logic [`RAMP_W-1:0] soft_q;
    logic [4:0]         quiet_q;
    always @(posedge sys_clk) begin
        if (rst) begin
            flt_q   <= 24'h0;
            soft_q  <= 24'h0;
            quiet_q <= 5'h0;
        end else begin
            flt_q  <= (all_on && !any_ss && any_low) ? flt_q + 24'h1 : 24'h0;
            soft_q <= boost_soft_start ? soft_q + 24'h1 : 24'h0;
            if (!(enable_pin && supply_lockout_good))
                quiet_q <= 5'h0;
            else if (quiet_q != 5'h1F)
                quiet_q <= quiet_q + 5'h1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_order;
        (!negative_rail_enable || boost_enable) &&
        (!positive_rail_enable || negative_rail_enable);
    endproperty
    a_order: assert property (p_order)
        else $error("rail enabled out of order");
    property p_ready;
        !ready_n |-> !any_ss && (all_on || $past(all_on));
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready low before startup done");
    property p_off;
        !enable_pin [*6] |-> !(boost_enable | negative_rail_enable |
                               positive_rail_enable);
    endproperty
    a_off: assert property (p_off)
        else $error("rail still on after pin low");
    property p_ramp;
        timing_ramp < RAMP_CYCLES;
    endproperty
    a_ramp: assert property (p_ramp)
        else $error("ramp beyond one period");
    property p_filter;
        $rose(ready_n) |-> flt_q >= READY_CYCLES || quiet_q < 5'h8;
    endproperty
    a_filter: assert property (p_filter)
        else $error("ready raised by a short fault");
    property p_delay;
        flt_q >= READY_CYCLES + 6 |-> ready_n;
    endproperty
    a_delay: assert property (p_delay)
        else $error("ready still low on lasting fault");
    property p_shut;
        flt_q <= RAMP_CYCLES + READY_CYCLES + 12;
    endproperty
    a_shut: assert property (p_shut)
        else $error("rails kept on past fault timer");
    property p_soft;
        $fell(boost_soft_start) && boost_enable |-> soft_q == RAMP_CYCLES;
    endproperty
    a_soft: assert property (p_soft)
        else $error("soft start not one ramp period");
    c_shut: cover property ($fell(boost_enable) && enable_pin);
    c_good: cover property ($fell(ready_n));
    c_flag: cover property ($rose(ready_n) && all_on);
endmodule // tri_rail_monitor
bind tri_rail_sequencer_fault_timer tri_rail_monitor #(
    .RAMP_CYCLES(RAMP_CYCLES),
    .READY_CYCLES(READY_CYCLES)
) mon (
    .sys_clk, .rst, .enable_pin, .supply_lockout_good,
    .boost_feedback_low, .negative_rail_feedback_low,
    .positive_rail_feedback_low, .boost_enable, .negative_rail_enable,
    .positive_rail_enable, .boost_soft_start, .negative_rail_soft_start,
    .positive_rail_soft_start, .ready_n, .timing_ramp
);
`default_nettype wire

// ---- testbench/tri_rail_sequencer_fault_timer_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sequencer_defs.vh"
module tri_rail_sequencer_fault_timer_bench;
    localparam int   RAMP = 64;
    localparam int   READY = 8;
    // Output snapshot: enables, soft starts, ready_n
    localparam [6:0] S_BOOST = 7'h49;
    localparam [6:0] S_NEG = 7'h65;
    localparam [6:0] S_POS = 7'h73;
    localparam [6:0] S_RUN = 7'h70;
    localparam [6:0] S_FLT = 7'h71;
    localparam [6:0] S_OFF = 7'h01;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        enable_pin = 1'b0;
    logic        supply_lockout_good = 1'b1;
    logic [2:0]  droop = 3'h0;
    logic [6:0]  last = 7'h01;
    logic [6:0]  e;
    logic [6:0]  exp_q[$];
    logic [31:0] seed = 32'h7272A6DC;
    int          mismatches = 0;
    int          checks = 0;
    wire boost_feedback_low, negative_rail_feedback_low;
    wire positive_rail_feedback_low, ready_n;
    wire boost_enable, negative_rail_enable, positive_rail_enable;
    wire boost_soft_start, negative_rail_soft_start, positive_rail_soft_start;
    wire [`RAMP_W-1:0] timing_ramp;
    wire [6:0] outs = {boost_enable, negative_rail_enable,
        positive_rail_enable, boost_soft_start, negative_rail_soft_start,
        positive_rail_soft_start, ready_n};
    tri_rail_sequencer_fault_timer #(
        .RAMP_CYCLES(24'h40),
        .READY_CYCLES(12'h8)
    ) uut (
        .sys_clk, .rst, .enable_pin, .supply_lockout_good,
        .boost_feedback_low, .negative_rail_feedback_low,
        .positive_rail_feedback_low, .boost_enable, .negative_rail_enable,
        .positive_rail_enable, .boost_soft_start, .negative_rail_soft_start,
        .positive_rail_soft_start, .ready_n, .timing_ramp
    );
    rail_plant_model plant (
        .boost_enable, .negative_rail_enable, .positive_rail_enable, .droop,
        .boost_feedback_low, .negative_rail_feedback_low,
        .positive_rail_feedback_low
    );
    initial forever #12.5 sys_clk = ~sys_clk;
    // ****************************
    // Helpers
    // ****************************
    function automatic int rnd(input int m);
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return int'(seed % m);
    endfunction
    task automatic cycles(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic startup;
        exp_q.push_back(S_BOOST);
        exp_q.push_back(S_NEG);
        exp_q.push_back(S_POS);
    endtask
    task automatic drain(input int n);
        for (int i = 0; i < n && exp_q.size() != 0; i++)
            @(negedge sys_clk);
        checks++;
        if (exp_q.size() != 0) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, outs, exp_q[0]);
            mismatches++;
            exp_q.delete();
        end
    endtask
    task automatic close_out;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Any output change must match the oldest note; none is unexpected
    always @(negedge sys_clk) begin
        if (!rst && outs !== last) begin
            checks++;
            e = last;
            if (exp_q.size() != 0)
                e = exp_q.pop_front();
            if (outs !== e) begin
                $display("[ERR] t=%0t got=%h exp=%h", $time, outs, e);
                mismatches++;
            end
            last = outs;
        end
    end
    initial begin
        cycles(20000);
        mismatches++;
        close_out;
    end
    initial begin
        cycles(20);
        rst = 1'b0;
        cycles(5);
        enable_pin = 1'b1;
        startup;
        exp_q.push_back(S_RUN);
        drain(3 * RAMP + 40);
        cycles(4);
        checks++;
        if (timing_ramp !== 24'h0) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, timing_ramp, 24'h0);
            mismatches++;
        end
        droop = 3'h1 << rnd(3);
        cycles(1 + rnd(READY - 3));
        droop = 3'h0;
        cycles(20);
        drain(1);
        droop = 3'h1 << rnd(3);
        exp_q.push_back(S_FLT);
        exp_q.push_back(S_RUN);
        cycles(READY + 10 + rnd(RAMP - 40));
        droop = 3'h0;
        drain(40);
        droop = 3'h1 << rnd(3);
        exp_q.push_back(S_FLT);
        exp_q.push_back(S_OFF);
        drain(RAMP + 60);
        droop = 3'h0;
        cycles(2 * RAMP);
        drain(1);
        enable_pin = 1'b0;
        cycles(8);
        enable_pin = 1'b1;
        startup;
        exp_q.push_back(S_RUN);
        drain(3 * RAMP + 40);
        enable_pin = 1'b0;
        exp_q.push_back(S_OFF);
        drain(12);
        droop = 3'h4;
        enable_pin = 1'b1;
        startup;
        exp_q.push_back(S_FLT);
        drain(3 * RAMP + 40);
        cycles(10);
        droop = 3'h0;
        exp_q.push_back(S_RUN);
        drain(40);
        enable_pin = 1'b0;
        supply_lockout_good = 1'b0;
        exp_q.push_back(S_OFF);
        drain(12);
        enable_pin = 1'b1;
        cycles(20);
        supply_lockout_good = 1'b1;
        startup;
        exp_q.push_back(S_RUN);
        drain(3 * RAMP + 40);
        close_out;
    end
endmodule // tri_rail_sequencer_fault_timer_bench
`default_nettype wire
